// ==== hw/tw_port.sv ====
// One two-wire port: status registers, bus watcher and master engine
`timescale 1ns/10ps
`include "tw_consts.svh"
module tw_port #(
	parameter logic [7:0] EVT_ADDR = `TW_EVT1_ADDR,
	parameter logic [7:0] BUS_ADDR = `TW_BUS1_ADDR
) (
	// Clocks and reset
	input  wire logic       ref_clk,
	input  wire logic       link_clk,
	input  wire logic       rst_n,
	// Special function register port
	input  wire logic [7:0] sfr_addr,
	input  wire logic       sfr_rd,
	input  wire logic       sfr_wr,
	input  wire logic [7:0] sfr_wdata,
	output logic      [7:0] sfr_rdata,
	// Bits of the neighbouring control, address and data registers
	input  wire logic       enable,
	input  wire logic       start_request,
	input  wire logic       stop_request,
	input  wire logic       bus_monitor_mode,
	input  wire logic       nack_request,
	input  wire logic [7:0] own_address_register,
	input  wire logic [7:0] tx_data,
	output logic      [7:0] rx_data,
	output logic            port_interrupt_flag,
	output logic            stop_request_clear,
	// Bus pins, open drain
	input  wire logic       scl_in,
	input  wire logic       sda_in,
	output logic            scl_out,
	output logic            scl_oe,
	output logic            sda_out,
	output logic            sda_oe
);
	tw_pkg::tw_sfr_t  r;
	tw_pkg::tw_sfr_t  r_nxt;
	tw_pkg::tw_link_t l;
	tw_pkg::tw_link_t l_nxt;
	logic [7:0]       pulse;

	assign pulse = r.e2 ^ r.ep;

	function automatic logic [7:0] tgl(input logic [7:0] v, input int b);
		logic [7:0] t;
		t = v;
		t[b] = ~v[b];
		return t;
	endfunction

	// Register side
	always_comb begin
		logic [7:0] keep;
		keep = 8'hff;
		r_nxt = r;
		r_nxt.ctl.en = enable;
		r_nxt.ctl.sta = start_request;
		r_nxt.ctl.sto = stop_request;
		r_nxt.ctl.nak = nack_request;
		r_nxt.ctl.bmm = bus_monitor_mode;
		r_nxt.ctl.pend = |(r.flags & `TW_PEND);
		r_nxt.own = own_address_register[7:1];
		r_nxt.txb = tx_data;
		r_nxt.e1 = l.ev;
		r_nxt.e2 = r.e1;
		r_nxt.ep = r.e2;
		r_nxt.v1 = l.lvl;
		r_nxt.v2 = r.v1;
		if (sfr_rd && sfr_addr == EVT_ADDR) begin
			keep = ~`TW_RDCLR;
		end
		if (sfr_wr && sfr_addr == EVT_ADDR) begin
			keep = keep & (sfr_wdata | ~`TW_WRCLR);
		end
		// A hardware event in the clearing cycle survives the clear
		r_nxt.flags = ((r.flags & keep) | pulse) & 8'hfe;
		r_nxt.stoclr = pulse[`TW_EV_STOPD];
		if (pulse[`TW_EV_RXD]) begin
			r_nxt.rx = l.rxh;
		end
		r_nxt.pif = |(r.flags & (r.ctl.bmm ? `TW_IRQ_MON : `TW_IRQ_NORM));
		if (sfr_rd) begin
			if (sfr_addr == EVT_ADDR) begin
				r_nxt.rdata = r.flags;
			end else if (sfr_addr == BUS_ADDR) begin
				r_nxt.rdata = {r.v2, 4'h0};
			end else begin
				r_nxt.rdata = `TW_REG_RST;
			end
		end
		if (!r.ctl.en) begin
			r_nxt.flags = `TW_REG_RST;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			r <= '0;
		end else begin
			r <= r_nxt;
		end
	end

	// Link side
	always_comb begin
		logic scl;
		logic sda;
		logic rise;
		logic fall;
		logic hiph;
		logic free;
		logic match;
		logic [7:0] byt;
		tw_pkg::tw_ctl_t c;
		scl = l.p2[1];
		sda = l.p2[0];
		c = l.c2;
		free = l.ph == 2'd0 && !c.pend;
		rise = scl && !l.pp[1];
		fall = !scl && l.pp[1];
		hiph = l.st inside {tw_pkg::S_BHI, tw_pkg::S_AHI, tw_pkg::S_RS2, tw_pkg::S_STOP2};
		byt = {l.ssh[6:0], sda};
		match = l.expa && (byt[7:1] == r.own || byt[7:1] == `TW_GCALL);
		l_nxt = l;
		l_nxt.p1 = {scl_in, sda_in};
		l_nxt.p2 = l.p1;
		l_nxt.pp = l.p2;
		l_nxt.c1 = r.ctl;
		l_nxt.c2 = l.c1;
		if (l.cnt != 6'd0 && (scl || !hiph)) begin
			l_nxt.cnt = l.cnt - 6'd1;
		end
		if (l.ph == 2'd1 && c.pend) begin
			l_nxt.ph = 2'd2;
		end else if (l.ph == 2'd2 && !c.pend) begin
			l_nxt.ph = 2'd0;
		end
		// Bus watcher runs for every bus owner, our own frames included
		if (scl && l.pp[1] && l.pp[0] && !sda) begin
			l_nxt.ev = tgl(l.ev, `TW_EV_RSTA);
			l_nxt.lvl.bb = 1'b1;
			l_nxt.lvl.adm = 1'b0;
			l_nxt.expa = 1'b1;
			l_nxt.scnt = 4'd0;
		end else if (scl && l.pp[1] && !l.pp[0] && sda) begin
			if (l.scnt > 4'd1) begin
				l_nxt.ev = tgl(l.ev, `TW_EV_BERR);
			end
			if (!l.master && (l.lvl.adm || c.bmm)) begin
				l_nxt.ev = tgl(l_nxt.ev, `TW_EV_RSTO);
			end
			l_nxt.lvl.bb = 1'b0;
			l_nxt.lvl.adm = 1'b0;
			l_nxt.expa = 1'b0;
		end else if (rise) begin
			l_nxt.ssh = byt;
			l_nxt.scnt = (l.scnt == 4'd8) ? 4'd0 : l.scnt + 4'd1;
			l_nxt.lvl.ack = (l.scnt == 4'd8) ? !sda : l.lvl.ack;
			if (l.scnt == 4'd7 && !l.master) begin
				l_nxt.expa = 1'b0;
				if (match) begin
					l_nxt.lvl.adm = 1'b1;
				end
				if (match || l.lvl.adm || c.bmm) begin
					l_nxt.rxh = byt;
					l_nxt.ev = tgl(l.ev, `TW_EV_RXD);
					l_nxt.sack = (match || l.lvl.adm) && !c.bmm && !c.nak;
					l_nxt.ph = c.bmm ? 2'd0 : 2'd1;
				end
			end
		end
		case (l.st)
			tw_pkg::S_IDLE: begin
				// Slave receiver: ack slot and clock stretch until the pending flags clear
				if (fall && l.scnt == 4'd8) begin
					l_nxt.sda_oe = l.sack;
				end else if (fall) begin
					l_nxt.sda_oe = 1'b0;
					l_nxt.sack = 1'b0;
				end
				l_nxt.scl_oe = l.lvl.adm && l.scnt == 4'd0 && !scl && l.ph != 2'd0;
				if (c.sta && !c.sto && !l.lvl.bb) begin
					l_nxt.st = tw_pkg::S_START;
					l_nxt.cnt = 6'(`TW_HALF_CYC);
					l_nxt.sda_oe = 1'b1;
					l_nxt.scl_oe = 1'b0;
				end
			end
			tw_pkg::S_START: begin
				if (l.cnt == 6'd0) begin
					l_nxt.scl_oe = 1'b1;
					l_nxt.master = 1'b1;
					l_nxt.txm = 1'b1;
					l_nxt.lvl.dir = 1'b1;
					l_nxt.lvl.bb = 1'b1;
					l_nxt.ev = tgl(l.ev, `TW_EV_TSTA);
					l_nxt.ph = 2'd1;
					l_nxt.afterb = 1'b0;
					l_nxt.first = 1'b1;
					l_nxt.st = tw_pkg::S_HOLD;
				end
			end
			tw_pkg::S_HOLD: begin
				l_nxt.scl_oe = 1'b1;
				if (c.sto) begin
					l_nxt.txm = 1'b0;
					l_nxt.sda_oe = 1'b1;
					l_nxt.cnt = 6'(`TW_HALF_CYC);
					l_nxt.st = tw_pkg::S_STOP;
				end else if (c.sta && l.afterb) begin
					l_nxt.sda_oe = 1'b0;
					l_nxt.cnt = 6'(`TW_HALF_CYC);
					l_nxt.st = tw_pkg::S_RS1;
				end else if (free) begin
					// Buffer is taken only after the flags clear, so it is stable
					l_nxt.bytx = l.txm;
					l_nxt.sh = l.txm ? r.txb : 8'hff;
					l_nxt.sda_oe = l.txm && !r.txb[7];
					l_nxt.akn = c.nak;
					l_nxt.bitn = 4'd0;
					l_nxt.cnt = 6'(`TW_HALF_CYC);
					l_nxt.st = tw_pkg::S_BLO;
				end
			end
			tw_pkg::S_RS1: begin
				if (l.cnt == 6'd0) begin
					l_nxt.scl_oe = 1'b0;
					l_nxt.cnt = 6'(`TW_HALF_CYC);
					l_nxt.st = tw_pkg::S_RS2;
				end
			end
			tw_pkg::S_RS2: begin
				if (l.cnt == 6'd0) begin
					l_nxt.sda_oe = 1'b1;
					l_nxt.cnt = 6'(`TW_HALF_CYC);
					l_nxt.st = tw_pkg::S_START;
				end
			end
			tw_pkg::S_BLO, tw_pkg::S_ALO: begin
				if (l.cnt == 6'd0) begin
					l_nxt.scl_oe = 1'b0;
					l_nxt.cnt = 6'(`TW_HALF_CYC);
					l_nxt.st = (l.st == tw_pkg::S_BLO) ? tw_pkg::S_BHI : tw_pkg::S_AHI;
				end
			end
			tw_pkg::S_BHI: begin
				if (l.cnt == 6'd0) begin
					if (l.bytx && l.master && l.sh[7] && !sda) begin
						l_nxt.master = 1'b0;
						l_nxt.arl = 1'b1;
						l_nxt.txm = 1'b0;
						l_nxt.lvl.dir = 1'b0;
					end
					l_nxt.sh = {l.sh[6:0], sda};
					l_nxt.bitn = l.bitn + 4'd1;
					l_nxt.scl_oe = 1'b1;
					l_nxt.cnt = 6'(`TW_HALF_CYC);
					if (l.bitn == 4'd7) begin
						l_nxt.sda_oe = !l.bytx && !l.akn;
						l_nxt.st = tw_pkg::S_ALO;
					end else begin
						l_nxt.sda_oe = l.bytx && l_nxt.master && !l.sh[6];
						l_nxt.st = tw_pkg::S_BLO;
					end
				end
			end
			tw_pkg::S_AHI: begin
				if (l.cnt == 6'd0) begin
					l_nxt.lvl.ack = !sda;
					l_nxt.rxh = l.sh;
					l_nxt.sda_oe = 1'b0;
					l_nxt.first = 1'b0;
					if (l.arl) begin
						l_nxt.ev = tgl(tgl(l.ev, `TW_EV_ARL), `TW_EV_RXD);
						l_nxt.arl = 1'b0;
						l_nxt.scl_oe = 1'b0;
						l_nxt.st = tw_pkg::S_IDLE;
					end else begin
						l_nxt.ev = tgl(l.ev, l.bytx ? `TW_EV_TXD : `TW_EV_RXD);
						if (l.bytx && l.first && l.sh[0]) begin
							l_nxt.txm = 1'b0;
							l_nxt.lvl.dir = 1'b0;
						end
						l_nxt.scl_oe = 1'b1;
						l_nxt.afterb = 1'b1;
						l_nxt.ph = 2'd1;
						l_nxt.st = tw_pkg::S_HOLD;
					end
				end
			end
			tw_pkg::S_STOP: begin
				if (l.cnt == 6'd0) begin
					l_nxt.scl_oe = 1'b0;
					l_nxt.cnt = 6'(`TW_HALF_CYC);
					l_nxt.st = tw_pkg::S_STOP2;
				end
			end
			tw_pkg::S_STOP2: begin
				if (l.cnt == 6'd0) begin
					l_nxt.sda_oe = 1'b0;
					l_nxt.master = 1'b0;
					l_nxt.lvl.dir = 1'b0;
					l_nxt.lvl.bb = 1'b0;
					l_nxt.ph = 2'd0;
					l_nxt.ev = tgl(l.ev, `TW_EV_STOPD);
					l_nxt.st = tw_pkg::S_IDLE;
				end
			end
			default: l_nxt.st = tw_pkg::S_IDLE;
		endcase
		// Disabled port: pins released, all state cleared except syncs and toggles
		if (!c.en) begin
			l_nxt = '0;
			l_nxt.p1 = {scl_in, sda_in};
			l_nxt.p2 = l.p1;
			l_nxt.pp = l.p1;
			l_nxt.c1 = r.ctl;
			l_nxt.c2 = l.c1;
			l_nxt.ev = l.ev;
		end
	end

	always_ff @(posedge link_clk or negedge rst_n) begin
		if (!rst_n) begin
			l <= '0;
		end else begin
			l <= l_nxt;
		end
	end

	assign sfr_rdata = r.rdata;
	assign rx_data = r.rx;
	assign port_interrupt_flag = r.pif;
	assign stop_request_clear = r.stoclr;
	assign scl_out = l.zr;
	assign sda_out = l.zr;
	assign scl_oe = l.scl_oe;
	assign sda_oe = l.sda_oe;

	property p_rdclr;
		@(posedge ref_clk) disable iff (!rst_n)
		(sfr_rd && sfr_addr == EVT_ADDR && pulse == 8'h00) |=> (r.flags & `TW_RDCLR) == 8'h00;
	endproperty
	a_rdclr: assert property (p_rdclr) else $error("read left flags set");
	property p_berr;
		@(posedge ref_clk) disable iff (!rst_n)
		(pulse[`TW_EV_BERR] && r.ctl.en) |=> r.flags[`TW_EV_BERR];
	endproperty
	a_berr: assert property (p_berr) else $error("bus error lost");
	property p_setwin;
		@(posedge ref_clk) disable iff (!rst_n)
		(((pulse & `TW_PEND) != 8'h00) && r.ctl.en) |=>
			((r.flags & $past(pulse) & `TW_PEND) == ($past(pulse) & `TW_PEND));
	endproperty
	a_setwin: assert property (p_setwin) else $error("done flag lost");
	property p_pif_clr;
		@(posedge ref_clk) disable iff (!rst_n)
		(r.flags == 8'h00) [*2] |=> !r.pif;
	endproperty
	a_pif_clr: assert property (p_pif_clr) else $error("interrupt stuck");
	property p_rsta_mask;
		@(posedge ref_clk) disable iff (!rst_n)
		(!r.ctl.bmm && r.flags == 8'h02) |=> !r.pif;
	endproperty
	a_rsta_mask: assert property (p_rsta_mask) else $error("start irq unmasked");
	property p_stoclr;
		@(posedge ref_clk) disable iff (!rst_n)
		pulse[`TW_EV_STOPD] |=> r.stoclr ##1 !r.stoclr;
	endproperty
	a_stoclr: assert property (p_stoclr) else $error("stop clear pulse bad");
	property p_busrd;
		@(posedge ref_clk) disable iff (!rst_n)
		(sfr_rd && sfr_addr == BUS_ADDR) |=> sfr_rdata == {$past(r.v2), 4'h0};
	endproperty
	a_busrd: assert property (p_busrd) else $error("bus state read wrong");
	property p_hold;
		@(posedge link_clk) disable iff (!rst_n)
		(l.st == tw_pkg::S_HOLD) |-> l.scl_oe;
	endproperty
	a_hold: assert property (p_hold) else $error("clock not held");
	property p_ack;
		@(posedge link_clk) disable iff (!rst_n)
		(l.st == tw_pkg::S_AHI && !l.bytx && l.master) |-> l.sda_oe == !l.akn;
	endproperty
	a_ack: assert property (p_ack) else $error("wrong ack driven");
	property p_msb;
		@(posedge link_clk) disable iff (!rst_n)
		(l.st == tw_pkg::S_BLO && l.bytx && l.master) |-> l.sda_oe == !l.sh[7];
	endproperty
	a_msb: assert property (p_msb) else $error("bit order wrong");
	property p_start;
		@(posedge link_clk) disable iff (!rst_n)
		(l.st == tw_pkg::S_START && l.cnt == 6'd0 && l.c2.en) |=> l.lvl.dir && l.master;
	endproperty
	a_start: assert property (p_start) else $error("start not taken");
	c_txd: cover property (@(posedge ref_clk) pulse[`TW_EV_TXD]);
	c_rxd: cover property (@(posedge ref_clk) pulse[`TW_EV_RXD]);
	c_berr: cover property (@(posedge ref_clk) pulse[`TW_EV_BERR]);
	c_stop: cover property (@(posedge ref_clk) r.stoclr);
endmodule

// ==== hw/tw_consts.svh ====
// Constants for the two-wire port status and master block
// Overview of operation
// - Nack request set means not-acknowledge next byte
// - Stop off byte boundary sets bus error
// - Event status read clears error, loss, stop, start
// - Arbitration loss flags, drops to unaddressed slave
// - Addressed slave or monitor mode sees any stop, sets received stop
// - Transmit done holds bus until software clears
// - Receive done must clear before next byte
// - Start sent holds bus until software clears
// - Received start interrupts only in monitor mode
// - Bus busy follows start and stop
// - Address or general call sets address match
// - Direction bit shows transmit one, receive zero
// - Ack status captures each byte's acknowledge
// - Reset leaves port a slave receiver
// - Start request waits free bus, drives start
// - First byte carries address and direction bit
// - Clearing transmit done sends transmit buffer
// - Start request as master gives repeated start
// - Stop switches to receive, auto-clears request
// - Lost driven one keeps clocking, buffers byte
// - Read address ack sets done, enters receive
// - Master receive flags byte, resumes on clear
// - Interrupt flag follows enabled status sources
// - Bytes shift most significant bit first
// - Stop after current byte, stop before start
`ifndef TW_CONSTS_SVH
`define TW_CONSTS_SVH
`define TW_EVT1_ADDR 8'h9e
`define TW_BUS1_ADDR 8'h9f
`define TW_EVT2_ADDR 8'hda
`define TW_BUS2_ADDR 8'hdb
`define TW_REG_RST   8'h00
`define TW_EV_BERR   7
`define TW_EV_ARL    6
`define TW_EV_RSTO   5
`define TW_EV_TXD    4
`define TW_EV_RXD    3
`define TW_EV_TSTA   2
`define TW_EV_RSTA   1
`define TW_EV_STOPD  0
`define TW_RDCLR     8'he2
`define TW_WRCLR     8'h1c
`define TW_PEND      8'h1c
`define TW_IRQ_MON   8'hfe
`define TW_IRQ_NORM  8'hfc
`define TW_GCALL     7'h00
`define TW_LINK_NS   160
`define TW_HALF_NS   5000
`define TW_HALF_CYC  (`TW_HALF_NS / `TW_LINK_NS)
`endif

// ==== hw/tw_pkg.sv ====
// Types for the two-wire port
package tw_pkg;
	typedef enum logic [3:0] {
		S_IDLE, S_START, S_HOLD, S_RS1, S_RS2, S_BLO, S_BHI,
		S_ALO, S_AHI, S_STOP, S_STOP2
	} tw_state_t;
	typedef struct packed {
		logic en;
		logic sta;
		logic sto;
		logic nak;
		logic bmm;
		logic pend;
	} tw_ctl_t;
	typedef struct packed {
		logic bb;
		logic adm;
		logic dir;
		logic ack;
	} tw_lvl_t;
	typedef struct packed {
		tw_state_t st;
		logic [5:0] cnt;
		logic [3:0] bitn;
		logic [7:0] sh;
		logic       master;
		logic       txm;
		logic       bytx;
		logic       first;
		logic       arl;
		logic       afterb;
		logic [1:0] ph;
		logic       akn;
		tw_lvl_t    lvl;
		logic       expa;
		logic [3:0] scnt;
		logic [7:0] ssh;
		logic       sack;
		logic [7:0] ev;
		logic [7:0] rxh;
		logic       scl_oe;
		logic       sda_oe;
		logic       zr;
		tw_ctl_t    c1;
		tw_ctl_t    c2;
		logic [1:0] p1;
		logic [1:0] p2;
		logic [1:0] pp;
	} tw_link_t;
	typedef struct packed {
		tw_ctl_t    ctl;
		logic [6:0] own;
		logic [7:0] txb;
		logic [7:0] e1;
		logic [7:0] e2;
		logic [7:0] ep;
		tw_lvl_t    v1;
		tw_lvl_t    v2;
		logic [7:0] flags;
		logic [7:0] rdata;
		logic [7:0] rx;
		logic       pif;
		logic       stoclr;
	} tw_sfr_t;
endpackage

// ==== dv/tw_slave_model.sv ====
// Behavioural two-wire slave that answers the port when it is master
`timescale 1ns/10ps
module tw_slave_model #(
	parameter logic [6:0] ADDR = 7'h2a
) (
	// Bus wires, open drain
	input  wire logic       scl,
	input  wire logic       sda,
	output logic            scl_low,
	output logic            sda_low,
	// Bench control and view
	input  wire logic       slow,
	input  wire logic [7:0] rd_byte,
	output logic      [7:0] got,
	output logic            got_nack
);
	logic [7:0] sh = 8'h00;
	logic       pscl = 1'b1;
	logic       psda = 1'b1;
	logic       sel = 1'b0;
	logic       rd = 1'b0;
	logic       adr = 1'b0;
	int         cnt = 0;
	initial begin
		scl_low = 1'b0;
		sda_low = 1'b0;
		got = 8'h00;
		got_nack = 1'b0;
	end
	// Released lines go high through the pull-ups, so no stale level survives
	always @(scl or sda) begin
		if (scl && pscl && psda && !sda) begin
			cnt = 0;
			adr = 1'b1;
			sel = 1'b0;
			got_nack = 1'b0;
		end else if (scl && pscl && !psda && sda) begin
			sel = 1'b0;
		end else if (scl && !pscl) begin
			if (cnt < 8)
				sh = {sh[6:0], sda};
			else if (sel && rd)
				got_nack = sda;
			cnt = cnt + 1;
		end else if (!scl && pscl) begin
			if (cnt == 8 && adr) begin
				sel = (sh[7:1] == ADDR);
				rd = sh[0];
				adr = 1'b0;
				sda_low = sel;
			end else if (cnt == 8) begin
				if (sel && !rd)
					got = sh;
				sda_low = sel && !rd;
			end else if (cnt == 9) begin
				cnt = 0;
				sda_low = 1'b0;
				if (sel && rd && got_nack)
					sel = 1'b0;
				if (sel && rd)
					sda_low = ~rd_byte[7];
			end else if (cnt > 0 && sel && rd && !adr) begin
				sda_low = ~rd_byte[7 - cnt];
			end
			// Slow answer: stretch the low half after the eighth bit, before the acknowledge clock
			if (slow && cnt == 8) begin
				scl_low = 1'b1;
				#10000;
				scl_low = 1'b0;
			end
		end
		pscl = scl;
		psda = sda;
	end
endmodule

// ==== dv/test_tw_port.sv ====
// Self-checking bench for one two-wire port against a slave model
`timescale 1ns/10ps
`include "tw_consts.svh"
module test_tw_port;
	localparam logic [7:0] EVT = `TW_EVT1_ADDR;
	localparam logic [7:0] BUS = `TW_BUS1_ADDR;
	localparam int         Q   = 50;
	logic       ref_clk = 1'b0;
	logic       link_clk = 1'b0;
	logic       rst_n = 1'b0;
	logic       sfr_rd = 1'b0;
	logic       sfr_wr = 1'b0;
	logic       enable = 1'b0;
	logic       start_request = 1'b0;
	logic       stop_request = 1'b0;
	logic       bus_monitor_mode = 1'b0;
	logic       nack_request = 1'b0;
	logic       slow = 1'b0;
	logic       x_scl_low = 1'b0;
	logic       x_sda_low = 1'b0;
	logic [7:0] sfr_addr = 8'h00;
	logic [7:0] sfr_wdata = 8'h00;
	logic [7:0] tx_data = 8'h00;
	logic [7:0] own_address_register = 8'h84;
	logic [7:0] sfr_rdata, rx_data, m_got;
	logic       port_interrupt_flag, stop_request_clear, m_nack, m_scl_low, m_sda_low;
	logic       scl_out, sda_out, scl_oe, sda_oe;
	int         error_cnt = 0;
	int         comparisons = 0;
	int         cycles = 0;
	int         m;
	wire logic  scl = !(scl_oe || m_scl_low || x_scl_low);
	wire logic  sda = !(sda_oe || m_sda_low || x_sda_low);

	tw_port i_dut (
		.ref_clk(ref_clk), .link_clk(link_clk), .rst_n(rst_n), .sfr_addr(sfr_addr),
		.sfr_rd(sfr_rd), .sfr_wr(sfr_wr), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
		.enable(enable), .start_request(start_request), .stop_request(stop_request),
		.bus_monitor_mode(bus_monitor_mode), .nack_request(nack_request),
		.own_address_register(own_address_register), .tx_data(tx_data), .rx_data(rx_data),
		.port_interrupt_flag(port_interrupt_flag), .stop_request_clear(stop_request_clear),
		.scl_in(scl), .sda_in(sda), .scl_out(scl_out), .scl_oe(scl_oe),
		.sda_out(sda_out), .sda_oe(sda_oe));
	tw_slave_model i_model (.scl(scl), .sda(sda), .scl_low(m_scl_low), .sda_low(m_sda_low),
		.slow(slow), .rd_byte(8'h96), .got(m_got), .got_nack(m_nack));

	initial forever #20 ref_clk = ~ref_clk;
	initial begin
		#7;
		forever #80 link_clk = ~link_clk;
	end
	// Control register side: stop request drops when the port reports it sent
	always @(posedge ref_clk) begin
		if (stop_request_clear === 1'b1)
			stop_request <= 1'b0;
		cycles++;
		if (cycles == 60000) begin
			error_cnt++;
			test_done();
		end
	end

	task automatic test_done();
		if (error_cnt == 0 && comparisons > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
		comparisons++;
		if (seen !== exp) begin
			error_cnt++;
			$display("unexpected %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic acc(input logic [7:0] a, input logic w, input logic [7:0] d,
		output logic [7:0] q);
		@(posedge ref_clk);
		sfr_addr <= a;
		sfr_rd <= !w;
		sfr_wr <= w;
		sfr_wdata <= d;
		@(posedge ref_clk);
		sfr_rd <= 1'b0;
		sfr_wr <= 1'b0;
		#1 q = sfr_rdata;
	endtask
	task automatic rc(input string n, input logic [7:0] a, input logic [7:0] e);
		logic [7:0] q;
		acc(a, 1'b0, 8'h00, q);
		chk(n, q, e);
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		logic [7:0] q;
		acc(a, 1'b1, d, q);
	endtask
	// Poll under a bound; polling reads also clear the read-cleared flags
	task automatic wflag(input int b);
		logic [7:0] q;
		q = 8'h00;
		for (int i = 0; i < 3000 && q[b] !== 1'b1; i++)
			acc(EVT, 1'b0, 8'h00, q);
		chk("event_flag", {7'h00, q[b]}, 8'h01);
	endtask
	task automatic wstop();
		for (int i = 0; i < 4000 && stop_request !== 1'b0; i++)
			@(posedge ref_clk);
		chk("stop_done", {7'h00, stop_request}, 8'h00);
		repeat (Q) @(posedge ref_clk);
	endtask
	task automatic xs();
		repeat (Q) @(posedge ref_clk);
		x_sda_low <= 1'b1;
		repeat (Q) @(posedge ref_clk);
		x_scl_low <= 1'b1;
	endtask
	task automatic xb(input logic [7:0] b, input int n);
		for (int i = 0; i < n; i++) begin
			repeat (Q) @(posedge ref_clk);
			x_sda_low <= (i < 8) ? ~b[7 - i] : 1'b0;
			repeat (Q) @(posedge ref_clk);
			x_scl_low <= 1'b0;
			repeat (Q) @(posedge ref_clk);
			x_scl_low <= 1'b1;
		end
		repeat (Q) @(posedge ref_clk);
	endtask
	// The port may hold the clock low, so wait for it to let go
	task automatic xp();
		repeat (Q) @(posedge ref_clk);
		x_sda_low <= 1'b1;
		repeat (Q) @(posedge ref_clk);
		x_scl_low <= 1'b0;
		for (int i = 0; i < 2000 && scl !== 1'b1; i++)
			@(posedge ref_clk);
		repeat (Q) @(posedge ref_clk);
		x_sda_low <= 1'b0;
		repeat (Q) @(posedge ref_clk);
	endtask

	initial begin
		repeat (3) @(posedge link_clk);
		@(posedge ref_clk);
		rst_n <= 1'b1;
		enable <= 1'b1;
		repeat (20) @(posedge ref_clk);
		rc("event_reset", EVT, 8'h00);
		rc("state_reset", BUS, 8'h00);
		chk("pin_levels", {6'h00, scl_out, sda_out}, 8'h00);
		rc("unmapped", 8'h55, 8'h00);
		wr(BUS, 8'hff);
		wr(EVT, 8'hff);
		rc("state_ro", BUS, 8'h00);
		rc("event_wr", EVT, 8'h00);
		chk("irq_idle", {7'h00, port_interrupt_flag}, 8'h00);
		start_request <= 1'b1;
		wflag(`TW_EV_TSTA);
		rc("start_state", BUS, 8'ha0);
		chk("irq_start", {7'h00, port_interrupt_flag}, 8'h01);
		tx_data <= {7'h2a, 1'b0};
		start_request <= 1'b0;
		wr(EVT, 8'hfb);
		wflag(`TW_EV_TXD);
		rc("addr_ack", BUS, 8'hb0);
		tx_data <= 8'ha5;
		wr(EVT, 8'hef);
		wflag(`TW_EV_TXD);
		chk("data_a5", m_got, 8'ha5);
		start_request <= 1'b1;
		wflag(`TW_EV_TSTA);
		tx_data <= {7'h2a, 1'b0};
		start_request <= 1'b0;
		wr(EVT, 8'he3);
		wflag(`TW_EV_TXD);
		slow <= 1'b1;
		tx_data <= 8'h3c;
		wr(EVT, 8'hef);
		wflag(`TW_EV_TXD);
		chk("data_3c", m_got, 8'h3c);
		slow <= 1'b0;
		stop_request <= 1'b1;
		tx_data <= 8'h77;
		wr(EVT, 8'hef);
		wstop();
		rc("after_stop", BUS, 8'h10);
		chk("no_extra", m_got, 8'h3c);
		start_request <= 1'b1;
		wflag(`TW_EV_TSTA);
		tx_data <= {7'h2a, 1'b1};
		start_request <= 1'b0;
		wr(EVT, 8'hfb);
		wflag(`TW_EV_TXD);
		rc("read_addr", BUS, 8'h90);
		wr(EVT, 8'hef);
		wflag(`TW_EV_RXD);
		chk("rx_first", rx_data, 8'h96);
		chk("ack_sent", {7'h00, m_nack}, 8'h00);
		nack_request <= 1'b1;
		wr(EVT, 8'hf7);
		wflag(`TW_EV_RXD);
		chk("nack_sent", {7'h00, m_nack}, 8'h01);
		stop_request <= 1'b1;
		nack_request <= 1'b0;
		wr(EVT, 8'hf7);
		wstop();
		rc("read_stop", BUS, 8'h00);
		rc("flush", EVT, 8'h00);
		// Another master holds the data line low through our first byte
		start_request <= 1'b1;
		wflag(`TW_EV_TSTA);
		tx_data <= 8'hd4;
		start_request <= 1'b0;
		x_sda_low <= 1'b1;
		wr(EVT, 8'hfb);
		wflag(`TW_EV_ARL);
		rc("arb_state", BUS, 8'hd0);
		chk("arb_byte", rx_data, 8'h00);
		x_sda_low <= 1'b0;
		repeat (Q) @(posedge ref_clk);
		rc("arb_flags", EVT, 8'h28);
		wr(EVT, 8'hf7);
		rc("arb_free", BUS, 8'h10);
		xs();
		xb(8'h84, 9);
		rc("addressed", BUS, 8'hd0);
		rc("addr_flags", EVT, 8'h0a);
		chk("addr_byte", rx_data, 8'h84);
		chk("irq_addr", {7'h00, port_interrupt_flag}, 8'h01);
		wr(EVT, 8'hf7);
		xp();
		rc("slave_stop", EVT, 8'h20);
		rc("adm_clear", BUS, 8'h10);
		for (m = 0; m < 2; m++) begin
			bus_monitor_mode <= m[0];
			xs();
			rc("busy_start", BUS, 8'h90);
			chk("irq_rx_start", {7'h00, port_interrupt_flag}, {7'h00, m[0]});
			xb(8'hff, 3);
			xp();
			rc("short_byte", EVT, m[0] ? 8'ha2 : 8'h82);
			rc("read_clear", EVT, 8'h00);
			chk("irq_clear", {7'h00, port_interrupt_flag}, 8'h00);
		end
		test_done();
	end
endmodule
